/* verilog/claac_top.sv */
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - transmit waits programmed bit periods after stop bit
// - long timeout expiry puts device in shutdown
// - long timeout code zero disables shutdown
// - decimation ratio 32/64/128/256, reset 256
// - sample frequency always 1 MHz
// - low bits select low-pass corner, reset zero
// - line rate codes 125k/250k/500k/1M
module claac_top
    import claac_pkg::*;
#(
    parameter int unsigned TICKS_PER_SEC = CLK_HZ
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic stopBitRx,
    input wire logic commActivity,
    output logic txAllowed,
    output logic [1:0] lineRate,
    output claac_chain_en_t chainEnable,
    output claac_adc_cfg_t adcConfig,
    output logic shortTimeout,
    output logic shutdownReq
);
    // register hit: word aligned, inside the decoded window
    function automatic logic regHit(input logic [31:0] addr, input logic [7:0] idx);
        regHit = (addr[31:10] == 22'h000000) && (addr[9:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    logic [7:0] rateReg;
    logic [7:0] chainReg;
    logic [7:0] holdoffReg;
    logic [7:0] timeoutReg;
    logic [7:0] cellReg;
    logic [7:0] next_rateReg;
    logic [7:0] next_chainReg;
    logic [7:0] next_holdoffReg;
    logic [7:0] next_timeoutReg;
    logic [7:0] next_cellReg;

    logic wrPend;
    logic [31:0] wrAddr;
    logic next_wrPend;
    logic [31:0] next_wrAddr;
    logic [31:0] next_hrdata;
    logic addrPhase;
    logic holdoffBusy;
    logic busAccess;

    assign addrPhase = hsel && htrans[1] && hready;
    // hsize is not checked: narrower writes still load the low byte
    assign busAccess = addrPhase;

    always_comb begin
        next_wrPend = addrPhase && hwrite;
        next_wrAddr = addrPhase ? haddr : wrAddr;
        next_rateReg = rateReg;
        next_chainReg = chainReg;
        next_holdoffReg = holdoffReg;
        next_timeoutReg = timeoutReg;
        next_cellReg = cellReg;
        if (wrPend) begin
            if (regHit(wrAddr, IDX_LINK_RATE)) begin
                next_rateReg = {6'h00, hwdata[RATE_LSB +: 2]};
            end
            if (regHit(wrAddr, IDX_CHAIN_EN)) begin
                next_chainReg = {2'b00, hwdata[5:0]};
            end
            if (regHit(wrAddr, IDX_HOLDOFF)) begin
                next_holdoffReg = hwdata[7:0];
            end
            if (regHit(wrAddr, IDX_TIMEOUT)) begin
                // reserved bit is stored as written; keeping it one is up to software
                next_timeoutReg = hwdata[7:0];
            end
            if (regHit(wrAddr, IDX_CELL_CONF)) begin
                next_cellReg = hwdata[7:0];
            end
        end
        // read data from next values so a read right after a write sees it
        next_hrdata = 32'h00000000;
        if (addrPhase && !hwrite) begin
            if (regHit(haddr, IDX_LINK_RATE)) begin
                next_hrdata = {24'h000000, next_rateReg};
            end else if (regHit(haddr, IDX_CHAIN_EN)) begin
                next_hrdata = {24'h000000, next_chainReg};
            end else if (regHit(haddr, IDX_HOLDOFF)) begin
                next_hrdata = {24'h000000, next_holdoffReg};
            end else if (regHit(haddr, IDX_TIMEOUT)) begin
                next_hrdata = {24'h000000, next_timeoutReg};
            end else if (regHit(haddr, IDX_CELL_CONF)) begin
                next_hrdata = {24'h000000, next_cellReg};
            end else if (regHit(haddr, IDX_STATUS)) begin
                next_hrdata = {29'h00000000, shutdownReq, shortTimeout, holdoffBusy};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wrPend <= 1'b0;
            wrAddr <= 32'h00000000;
            hrdata <= 32'h00000000;
            rateReg <= RST_LINK_RATE;
            chainReg <= RST_CHAIN_EN;
            holdoffReg <= RST_HOLDOFF;
            timeoutReg <= RST_TIMEOUT;
            cellReg <= RST_CELL_CONF;
        end else begin
            wrPend <= next_wrPend;
            wrAddr <= next_wrAddr;
            hrdata <= next_hrdata;
            rateReg <= next_rateReg;
            chainReg <= next_chainReg;
            holdoffReg <= next_holdoffReg;
            timeoutReg <= next_timeoutReg;
            cellReg <= next_cellReg;
        end
    end

    // zero wait states, unmapped addresses read zero and ignore writes
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // receivers are never forced on here; keeping them enabled is software's job
    assign chainEnable.lowSideTxEnable = chainReg[CE_LOW_TX];
    assign chainEnable.lowSideRxEnable = chainReg[CE_LOW_RX];
    assign chainEnable.highSideTxEnable = chainReg[CE_HIGH_TX];
    assign chainEnable.highSideRxEnable = chainReg[CE_HIGH_RX];
    assign chainEnable.alarmLineTxEnable = chainReg[CE_ALARM_TX];
    assign chainEnable.alarmLineRxEnable = chainReg[CE_ALARM_RX];
    assign lineRate = rateReg[RATE_LSB +: 2];
    assign adcConfig.decimationRatio = 9'd32 << cellReg[CC_DR_LSB +: 2];
    // reserved frequency codes fall back to the only supported rate
    assign adcConfig.sampleClockDiv = SAMPLE_DIV;
    assign adcConfig.lowpassCornerSel = cellReg[CC_CORNER_LSB +: 3];

    claac_holdoff u_holdoff (
        .clk(clk),
        .rst_b(rst_b),
        .stopBitRx(stopBitRx),
        .holdoffBitCount(holdoffReg),
        .lineRate(lineRate),
        .holdoffBusy(holdoffBusy)
    );
    assign txAllowed = !holdoffBusy;

    // communication timeouts, counted in whole seconds of silence
    logic [24:0] presc;
    logic [12:0] idleSec;
    logic [24:0] next_presc;
    logic [12:0] next_idleSec;
    logic next_shortTimeout;
    logic next_shutdownReq;
    logic [12:0] shortPeriod;
    logic [12:0] longPeriod;
    logic activity;
    logic secTick;
    logic shortExpired;
    logic longExpired;

    assign activity = commActivity || busAccess;
    assign secTick = (presc == 25'(TICKS_PER_SEC - 1));
    assign shortPeriod = timeoutSeconds(timeoutReg[TO_SHORT_LSB +: 3], 1'b0);
    assign longPeriod = timeoutSeconds(timeoutReg[TO_LONG_LSB +: 3], 1'b1);
    // one-cycle hit just after the count reaches the period; a level here would
    // keep the flag set through the activity that is meant to clear it
    assign shortExpired = (shortPeriod != TO_OFF) && (idleSec == shortPeriod)
        && (presc == 25'h0000000);
    assign longExpired = (longPeriod != TO_OFF) && (idleSec >= longPeriod);

    always_comb begin
        next_presc = (activity || secTick) ? 25'h0000000 : presc + 25'd1;
        next_idleSec = idleSec;
        if (activity) begin
            next_idleSec = 13'h0000;
        end else if (secTick && idleSec != 13'h1fff) begin
            next_idleSec = idleSec + 13'd1;
        end
        // expiry wins over the clearing activity in the same cycle
        next_shortTimeout = shortExpired || (shortTimeout && !activity);
        // shutdown is final until reset
        next_shutdownReq = shutdownReq || longExpired;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            presc <= 25'h0000000;
            idleSec <= 13'h0000;
            shortTimeout <= 1'b0;
            shutdownReq <= 1'b0;
        end else begin
            presc <= next_presc;
            idleSec <= next_idleSec;
            shortTimeout <= next_shortTimeout;
            shutdownReq <= next_shutdownReq;
        end
    end

    a_short_period: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(shortTimeout) |-> $past(idleSec) == $past(shortPeriod) && $past(shortPeriod) != 13'h0000)
        else $error("short timeout fired at wrong idle time");
    a_short_table: assert property (@(posedge clk) disable iff (!rst_b)
        timeoutReg[TO_SHORT_LSB +: 3] == 3'b100 |-> shortPeriod == 13'd60)
        else $error("short timeout code 100 is not one minute");
    a_long_shutdown: assert property (@(posedge clk) disable iff (!rst_b)
        longExpired |=> shutdownReq [*2])
        else $error("long timeout did not shut down");
    a_long_disabled: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(shutdownReq) |-> $past(timeoutReg[TO_LONG_LSB +: 3]) != 3'b000)
        else $error("shutdown with long timeout disabled");
    a_decim_write: assert property (@(posedge clk) disable iff (!rst_b)
        wrPend && regHit(wrAddr, IDX_CELL_CONF) && hwdata[6:5] == 2'b00
        |=> adcConfig.decimationRatio == 9'd32)
        else $error("decimation code 00 not ratio 32");
    a_decim_reset: assert property (@(posedge clk)
        $rose(rst_b) |-> adcConfig.decimationRatio == 9'd256 && adcConfig.lowpassCornerSel == 3'b000)
        else $error("converter config reset values wrong");
    a_sample_freq: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(cellReg[CC_FREQ_LSB +: 2]) |-> adcConfig.sampleClockDiv == 5'd20)
        else $error("sample frequency left 1 MHz");
    a_corner_write: assert property (@(posedge clk) disable iff (!rst_b)
        wrPend && regHit(wrAddr, IDX_CELL_CONF) |=> adcConfig.lowpassCornerSel == $past(hwdata[2:0]))
        else $error("low-pass corner not taken from write");
    a_rate_fast: assert property (@(posedge clk) disable iff (!rst_b)
        lineRate == 2'b11 |-> bitCycles(lineRate) == 8'd20)
        else $error("1 Mbps bit period wrong");

    c_shutdown: cover property (@(posedge clk) disable iff (!rst_b) $rose(shutdownReq));
    c_short_to: cover property (@(posedge clk) disable iff (!rst_b) $rose(shortTimeout));
    c_tx_held: cover property (@(posedge clk) disable iff (!rst_b) stopBitRx ##1 !txAllowed);
endmodule // claac_top
`default_nettype wire

/* shared/claac_pkg.sv */
package claac_pkg;

    // device clock
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_LINK_RATE = 8'h20;
    localparam logic [7:0] IDX_CHAIN_EN = 8'h21;
    localparam logic [7:0] IDX_HOLDOFF = 8'h22;
    localparam logic [7:0] IDX_TIMEOUT = 8'h23;
    localparam logic [7:0] IDX_CELL_CONF = 8'h24;
    localparam logic [7:0] IDX_STATUS = 8'h30;

    // reset values
    localparam logic [7:0] RST_LINK_RATE = 8'h01;
    localparam logic [7:0] RST_CHAIN_EN = 8'h3c;
    localparam logic [7:0] RST_HOLDOFF = 8'h00;
    localparam logic [7:0] RST_TIMEOUT = 8'h00;
    localparam logic [7:0] RST_CELL_CONF = 8'h60;

    // field positions
    localparam int RATE_LSB = 0;
    localparam int CE_LOW_TX = 5;
    localparam int CE_LOW_RX = 4;
    localparam int CE_HIGH_TX = 3;
    localparam int CE_HIGH_RX = 2;
    localparam int CE_ALARM_TX = 1;
    localparam int CE_ALARM_RX = 0;
    localparam int TO_SHORT_LSB = 4;
    localparam int TO_LONG_LSB = 0;
    localparam int CC_DR_LSB = 5;
    localparam int CC_FREQ_LSB = 3;
    localparam int CC_CORNER_LSB = 0;
    localparam int ST_HOLDOFF = 0;
    localparam int ST_SHORT_TO = 1;
    localparam int ST_SHUTDOWN = 2;

    // line rates in bits per second
    localparam int RATE_0_BPS = 125_000;
    localparam int RATE_1_BPS = 250_000;
    localparam int RATE_2_BPS = 500_000;
    localparam int RATE_3_BPS = 1_000_000;

    // converter sample frequency, same for every code
    localparam int SAMPLE_HZ = 1_000_000;
    localparam logic [4:0] SAMPLE_DIV = 5'(CLK_HZ / SAMPLE_HZ);

    // timeout periods in seconds
    localparam logic [12:0] TO_2S = 13'd2;
    localparam logic [12:0] TO_10S = 13'd10;
    localparam logic [12:0] TO_1MIN = 13'd60;
    localparam logic [12:0] TO_10MIN = 13'd600;
    localparam logic [12:0] TO_30MIN = 13'd1800;
    localparam logic [12:0] TO_LONG_C1 = 13'd1;
    localparam logic [12:0] TO_LONG_C7 = 13'd3600;
    localparam logic [12:0] TO_OFF = 13'd0;

    typedef struct packed {
        logic lowSideTxEnable;
        logic lowSideRxEnable;
        logic highSideTxEnable;
        logic highSideRxEnable;
        logic alarmLineTxEnable;
        logic alarmLineRxEnable;
    } claac_chain_en_t;

    typedef struct packed {
        logic [8:0] decimationRatio;
        logic [4:0] sampleClockDiv;
        logic [2:0] lowpassCornerSel;
    } claac_adc_cfg_t;

    // clock cycles in one bit period at the selected line rate
    function automatic logic [7:0] bitCycles(input logic [1:0] rate);
        case (rate)
            2'b00: bitCycles = 8'(CLK_HZ / RATE_0_BPS);
            2'b01: bitCycles = 8'(CLK_HZ / RATE_1_BPS);
            2'b10: bitCycles = 8'(CLK_HZ / RATE_2_BPS);
            default: bitCycles = 8'(CLK_HZ / RATE_3_BPS);
        endcase
    endfunction

    // timeout period in seconds; zero means the timeout is off
    function automatic logic [12:0] timeoutSeconds(input logic [2:0] code, input logic isLong);
        case (code)
            3'b001: timeoutSeconds = isLong ? TO_LONG_C1 : TO_OFF;
            3'b010: timeoutSeconds = TO_2S;
            3'b011: timeoutSeconds = TO_10S;
            3'b100: timeoutSeconds = TO_1MIN;
            3'b101: timeoutSeconds = TO_10MIN;
            3'b110: timeoutSeconds = TO_30MIN;
            3'b111: timeoutSeconds = isLong ? TO_LONG_C7 : TO_OFF;
            default: timeoutSeconds = TO_OFF;
        endcase
    endfunction

endpackage

/* verilog/claac_holdoff.sv */
`timescale 1ns/1ps
`default_nettype none
module claac_holdoff
    import claac_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stopBitRx,
    input wire logic [7:0] holdoffBitCount,
    input wire logic [1:0] lineRate,
    output logic holdoffBusy
);
    logic [7:0] cycCnt;
    logic [7:0] bitsLeft;
    logic busy;
    logic [7:0] next_cycCnt;
    logic [7:0] next_bitsLeft;
    logic next_busy;

    always_comb begin
        next_cycCnt = cycCnt;
        next_bitsLeft = bitsLeft;
        next_busy = busy;
        if (stopBitRx) begin
            // each new stop bit restarts the whole hold-off
            next_bitsLeft = holdoffBitCount;
            next_cycCnt = bitCycles(lineRate) - 8'd1;
            next_busy = (holdoffBitCount != 8'h00);
        end else if (busy) begin
            if (cycCnt == 8'h00) begin
                if (bitsLeft == 8'h01) begin
                    next_busy = 1'b0;
                end else begin
                    next_bitsLeft = bitsLeft - 8'd1;
                    // reload at the rate selected now, so a rate change applies per bit
                    next_cycCnt = bitCycles(lineRate) - 8'd1;
                end
            end else begin
                next_cycCnt = cycCnt - 8'd1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cycCnt <= 8'h00;
            bitsLeft <= 8'h00;
            busy <= 1'b0;
        end else begin
            cycCnt <= next_cycCnt;
            bitsLeft <= next_bitsLeft;
            busy <= next_busy;
        end
    end

    assign holdoffBusy = busy;

    // helper: length of the last hold-off against the length asked for
    logic [15:0] busyLen;
    logic [15:0] expLen;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busyLen <= 16'h0000;
            expLen <= 16'h0000;
        end else begin
            busyLen <= stopBitRx ? 16'h0000 : (busy ? busyLen + 16'd1 : busyLen);
            expLen <= stopBitRx ? 16'(holdoffBitCount * bitCycles(lineRate)) : expLen;
        end
    end

    a_holdoff_length: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(busy) |-> busyLen == expLen)
        else $error("hold-off length differs from programmed bit count");
    a_bit_reload: assert property (@(posedge clk) disable iff (!rst_b)
        stopBitRx && holdoffBitCount != 8'h00 |=> busy && cycCnt == bitCycles($past(lineRate)) - 8'd1)
        else $error("bit period reload wrong for line rate");
    a_stop_restart: assert property (@(posedge clk) disable iff (!rst_b)
        stopBitRx && busy |=> bitsLeft == $past(holdoffBitCount))
        else $error("hold-off not restarted on new stop bit");
    a_zero_count: assert property (@(posedge clk) disable iff (!rst_b)
        stopBitRx && holdoffBitCount == 8'h00 |=> !busy)
        else $error("zero hold-off must not block transmit");
    c_holdoff_done: cover property (@(posedge clk) disable iff (!rst_b) $fell(busy));
endmodule // claac_holdoff
`default_nettype wire

/* tb/claac_link_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module claac_link_peer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sendStop,
    input wire logic sendActivity,
    output logic stopBitRx,
    output logic commActivity
);
    // a neighbour ends its frame one clock after being asked; both lines idle low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stopBitRx <= 1'b0;
            commActivity <= 1'b0;
        end else begin
            stopBitRx <= sendStop;
            commActivity <= sendActivity;
        end
    end
endmodule // claac_link_peer
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import claac_pkg::*;
    localparam int TPS = 10;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic sendStop = 1'b0;
    logic sendActivity = 1'b0;
    logic stopBitRx;
    logic commActivity;
    logic txAllowed;
    logic [1:0] lineRate;
    claac_chain_en_t chainEnable;
    claac_adc_cfg_t adcConfig;
    logic shortTimeout;
    logic shutdownReq;
    int err_total = 0;
    int comparisons = 0;
    logic [31:0] rd;
    int span;
    always #25 clk = ~clk;
    claac_link_peer peer (.clk(clk), .rst_b(rst_b), .sendStop(sendStop),
        .sendActivity(sendActivity), .stopBitRx(stopBitRx), .commActivity(commActivity));
    claac_top #(.TICKS_PER_SEC(TPS)) uut (.clk(clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .stopBitRx(stopBitRx), .commActivity(commActivity), .txAllowed(txAllowed),
        .lineRate(lineRate), .chainEnable(chainEnable), .adcConfig(adcConfig),
        .shortTimeout(shortTimeout), .shutdownReq(shutdownReq));
    task automatic summarize();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic waitReady();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            summarize();
        end
    endtask
    // caller stands just after a rising edge; hrdata is read before that edge's updates land
    task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] wdata);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        waitReady();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h0, wdata};
        waitReady();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wdata);
        access(1'b1, idx, wdata);
    endtask
    task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        access(1'b0, idx, 8'h00);
        check(name, rd, {24'h0, exp});
    endtask
    // restart mode counts from the request edge, so the old span's tail adds two cycles
    task automatic holdoffSpan(input logic restart);
        int i;
        sendStop <= 1'b1;
        @(posedge clk);
        sendStop <= 1'b0;
        span = 0;
        for (i = 0; i < 8 && !restart && txAllowed !== 1'b0; i++) begin
            @(posedge clk);
        end
        while (txAllowed === 1'b0 && span < 6000) begin
            span++;
            @(posedge clk);
        end
        if (span >= 6000) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic idleUntil(input logic longSel, input int limit, output int n);
        n = 0;
        while ((longSel ? shutdownReq : shortTimeout) !== 1'b1 && n < limit) begin
            @(posedge clk);
            n++;
        end
        if (n >= limit) begin
            err_total++;
            summarize();
        end
    endtask
    initial begin
        int i;
        int n;
        logic [1:0] dr;
        int secs [7];
        int bps [4];
        secs = '{0, 2, 10, 60, 600, 1800, 0};
        bps = '{RATE_0_BPS, RATE_1_BPS, RATE_2_BPS, RATE_3_BPS};
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check("lineRate", 32'(lineRate), 32'h1);
        check("chainEnable", 32'(chainEnable), 32'h3c);
        check("ratio", 32'(adcConfig.decimationRatio), 32'd256);
        check("corner", 32'(adcConfig.lowpassCornerSel), 32'h0);
        check("txAllowed", 32'(txAllowed), 32'h1);
        check("hresp", 32'(hresp), 32'h0);
        check("hready", 32'(hready), 32'h1);
        rdchk("rateReg", IDX_LINK_RATE, 8'h01);
        rdchk("chainReg", IDX_CHAIN_EN, 8'h3c);
        rdchk("holdReg", IDX_HOLDOFF, 8'h00);
        rdchk("toReg", IDX_TIMEOUT, 8'h00);
        rdchk("cellReg", IDX_CELL_CONF, 8'h60);
        wr(8'h40, 8'hff);
        rdchk("unmapped", 8'h40, 8'h00);
        $display("test reset done");
        // addressed to this device alone, receivers kept on
        wr(IDX_CHAIN_EN, 8'h3f);
        rdchk("chainReg", IDX_CHAIN_EN, 8'h3f);
        check("chainEnable", 32'(chainEnable), 32'h3f);
        wr(IDX_CHAIN_EN, 8'h16);
        // a write lands at the data-phase edge; its outputs are seen one edge later
        @(posedge clk);
        check("chainEnable", 32'(chainEnable), 32'h16);
        for (i = 0; i < 4; i++) begin
            dr = 2'(i);
            wr(IDX_CELL_CONF, {1'b0, dr, dr, dr[0], dr});
            rdchk("cellReg", IDX_CELL_CONF, {1'b0, dr, dr, dr[0], dr});
            check("ratio", 32'(adcConfig.decimationRatio), 32'd32 << i);
            check("sampleDiv", 32'(adcConfig.sampleClockDiv), CLK_HZ / SAMPLE_HZ);
            check("corner", 32'(adcConfig.lowpassCornerSel), 32'({dr[0], dr}));
        end
        $display("test converter done");
        wr(IDX_HOLDOFF, 8'h01);
        for (i = 0; i < 4; i++) begin
            wr(IDX_LINK_RATE, 8'(i));
            @(posedge clk);
            check("lineRate", 32'(lineRate), 32'(i));
            holdoffSpan(1'b0);
            check("span1", 32'(span), CLK_HZ / bps[i]);
        end
        wr(IDX_HOLDOFF, 8'h02);
        holdoffSpan(1'b0);
        check("span2", 32'(span), 2 * (CLK_HZ / bps[3]));
        wr(IDX_HOLDOFF, 8'hff);
        holdoffSpan(1'b0);
        check("span255", 32'(span), 255 * (CLK_HZ / bps[3]));
        wr(IDX_HOLDOFF, 8'h00);
        holdoffSpan(1'b0);
        check("span0", 32'(span), 32'h0);
        wr(IDX_HOLDOFF, 8'h01);
        sendStop <= 1'b1;
        @(posedge clk);
        sendStop <= 1'b0;
        repeat (10) @(posedge clk);
        holdoffSpan(1'b1);
        check("restart", 32'(span), CLK_HZ / bps[3] + 2);
        $display("test holdoff done");
        for (i = 0; i < 7; i++) begin
            wr(IDX_TIMEOUT, {1'b0, 3'(i + 1), 1'b1, 3'b000});
            if (secs[i] == 0) begin
                repeat (50) @(posedge clk);
                check("shortOff", 32'(shortTimeout), 32'h0);
            end else begin
                idleUntil(1'b0, 20000, n);
                check("shortSpan", 32'(n >= secs[i] * TPS - 2 && n <= secs[i] * TPS + 4), 1);
            end
            check("noShutdown", 32'(shutdownReq), 32'h0);
        end
        sendActivity <= 1'b1;
        @(posedge clk);
        sendActivity <= 1'b0;
        repeat (3) @(posedge clk);
        check("shortClear", 32'(shortTimeout), 32'h0);
        wr(IDX_TIMEOUT, 8'h09);
        idleUntil(1'b1, 200, n);
        check("longSpan", 32'(n >= TPS - 2 && n <= TPS + 4), 32'h1);
        wr(IDX_TIMEOUT, 8'h08);
        repeat (30) @(posedge clk);
        check("sticky", 32'(shutdownReq), 32'h1);
        rdchk("toRegRsv", IDX_TIMEOUT, 8'h08);
        rdchk("status", IDX_STATUS, 8'h04);
        wr(IDX_STATUS, 8'hff);
        rdchk("statusRo", IDX_STATUS, 8'h04);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check("shutdownRst", 32'(shutdownReq), 32'h0);
        rdchk("toReg", IDX_TIMEOUT, 8'h00);
        wr(IDX_TIMEOUT, 8'h0a);
        idleUntil(1'b1, 200, n);
        check("longSpan2", 32'(n >= 2 * TPS - 2 && n <= 2 * TPS + 4), 32'h1);
        $display("test timeout done");
        summarize();
    end
endmodule // tb_top
`default_nettype wire
